// >>> hw/ubsm_mapper.sv
// Upstream burst symbol mapper: loads a burst, maps it, releases it on its grid slot
`default_nettype none

module ubsm_mapper
   import ubsm_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Burst parameters
   input  wire logic              cfg_valid,
   input  wire ubsm_cfg_t         cfg,
   output var  logic              cfg_ready,
   // Serial burst bits
   input  wire logic              bit_valid,
   input  wire ubsm_bit_t         bit_in,
   output var  logic              bit_ready,
   // Symbols to the pulse-shaping modulator
   output var  logic              sym_valid,
   output var  ubsm_sym_t         sym,
   output var  logic              tx_on,
   // Status
   output var  logic              burst_done,
   output var  logic [SLOT_W-1:0] grid_index
);

   localparam logic [6:0] GRID_LAST = 7'(GRID_CYC - 1);
   localparam logic [8:0] GRID_MOD  = 9'(GRID_CYC);
   localparam logic [ADDR_W:0] FULL_CNT = (ADDR_W + 1)'(BUF_DEPTH - 1);

   ubsm_regs_t r;
   ubsm_regs_t next_r;

   logic              wr_en;
   logic [CODE_W-1:0] wr_data;
   logic              rd_en;
   logic [CODE_W-1:0] rd_data;

   // Symbols per grid period; the grid holds 16 at the top rate
   function automatic logic [7:0] sym_step(input ubsm_rate_t rate);
      logic [7:0] s;
      s = 8'h01;
      case (rate)
         RATE_160:  s = 8'(FAST_SYM_PER_GRID / 16);
         RATE_320:  s = 8'(FAST_SYM_PER_GRID / 8);
         RATE_640:  s = 8'(FAST_SYM_PER_GRID / 4);
         RATE_1280: s = 8'(FAST_SYM_PER_GRID / 2);
         RATE_2560: s = 8'(FAST_SYM_PER_GRID);
         default:   s = 8'h01;
      endcase
      return s;
   endfunction : sym_step

   // Quadrant position counted in 90 degree steps from 11
   function automatic logic [1:0] quad_pos(input logic [1:0] q);
      logic [1:0] p;
      p = 2'h0;
      case (q)
         2'b11:   p = 2'h0;
         2'b01:   p = 2'h1;
         2'b00:   p = 2'h2;
         default: p = 2'h3;
      endcase
      return p;
   endfunction : quad_pos

   function automatic logic [1:0] pos_quad(input logic [1:0] p);
      logic [1:0] q;
      q = 2'b11;
      case (p)
         2'h0:    q = 2'b11;
         2'h1:    q = 2'b01;
         2'h2:    q = 2'b00;
         default: q = 2'b10;
      endcase
      return q;
   endfunction : pos_quad

   // Rotation amount in 90 degree steps from the two high input bits
   function automatic logic [1:0] rot_amt(input logic [1:0] b);
      logic [1:0] a;
      a = 2'h0;
      case (b)
         2'b00:   a = 2'h0;
         2'b01:   a = 2'h1;
         2'b11:   a = 2'h2;
         default: a = 2'h3;
      endcase
      return a;
   endfunction : rot_amt

   // Amplitude on one axis; high bit set is the positive half
   function automatic logic signed [2:0] axis_lvl(input logic hi, input logic lo,
                                                  input logic qam);
      logic signed [2:0] v;
      if (!qam) begin
         v = hi ? 3'sh1 : -3'sh1;
      end else if (lo) begin
         v = hi ? 3'sh1 : -3'sh1;
      end else begin
         v = hi ? 3'sh3 : -3'sh3;
      end
      return v;
   endfunction : axis_lvl

   function automatic ubsm_sym_t map_sym(input logic [CODE_W-1:0] c, input ubsm_cfg_t k);
      ubsm_sym_t s;
      logic      il;
      logic      ql;
      il = c[1];
      ql = c[0];
      // Odd quadrants swap the low bits so the inner pattern turns with the quadrant
      if (k.qam16 && k.diff_en && (c[3] ^ c[2])) begin
         il = c[0];
         ql = c[1];
      end
      s.code  = c;
      s.i_lvl = axis_lvl(c[3], il, k.qam16);
      s.q_lvl = axis_lvl(c[2], ql, k.qam16);
      return s;
   endfunction : map_sym

   ubsm_sym_mem #(
      .WIDTH (CODE_W),
      .DEPTH (BUF_DEPTH),
      .AW    (ADDR_W)
   ) u_buf (
      .sys_clk (sys_clk),
      .wr_en   (wr_en),
      .wr_addr (r.wr_cnt[ADDR_W-1:0]),
      .wr_data (wr_data),
      .rd_en   (rd_en),
      .rd_addr (r.rd_cnt[ADDR_W-1:0]),
      .rd_data (rd_data)
   );

   always_comb begin
      logic [3:0]        sh;
      logic [2:0]        n;
      logic [2:0]        need;
      logic [3:0]        c;
      logic [1:0]        hi;
      logic [8:0]        acc_sum;
      logic              boundary;
      sh       = '0;
      n        = '0;
      c        = '0;
      hi       = '0;
      acc_sum  = '0;
      boundary = 1'b0;
      next_r   = r;
      wr_en    = 1'b0;
      wr_data  = '0;
      rd_en    = 1'b0;
      next_r.burst_done = 1'b0;
      next_r.sym_valid  = 1'b0;
      need     = r.cfg.qam16 ? QAM_BITS : QPSK_BITS;

      // Free-running 6.25 us grid; cycle 0 is the boundary
      boundary = (r.grid_cyc == 7'h00);
      if (r.grid_cyc == GRID_LAST) begin
         next_r.grid_cyc = 7'h00;
         next_r.grid_idx = r.grid_idx + 1'b1;
      end else begin
         next_r.grid_cyc = r.grid_cyc + 1'b1;
      end

      case (r.st)
         ST_IDLE: begin
            if (cfg_valid && r.cfg_ready) begin
               next_r.cfg       = cfg;
               next_r.cfg_ready = 1'b0;
               next_r.bit_ready = 1'b1;
               next_r.wr_cnt    = '0;
               next_r.rd_cnt    = '0;
               next_r.nbits     = '0;
               next_r.shreg     = '0;
               next_r.quad_prev = QUAD_REF;
               // A burst without the near-continuous flag lets the envelope fall
               next_r.tx_on     = r.tx_on & cfg.near_cont;
               next_r.st        = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (bit_valid && r.bit_ready) begin
               // First bit in lands on top as it shifts up
               sh = {r.shreg[2:0], bit_in.data};
               n  = r.nbits + 3'h1;
               if (n == need || bit_in.last) begin
                  // A short final symbol is padded with zeros below its bits
                  if (r.cfg.qam16) begin
                     c = sh << (3'h4 - n);
                  end else begin
                     c = {2'(sh[1:0] << (3'h2 - n)), 2'b00};
                  end
                  if (r.cfg.diff_en) begin
                     hi = pos_quad(quad_pos(r.quad_prev) + rot_amt(c[3:2]));
                  end else begin
                     hi = c[3:2];
                  end
                  wr_en            = 1'b1;
                  wr_data          = {hi, c[1:0]};
                  next_r.quad_prev = hi;
                  next_r.wr_cnt    = r.wr_cnt + 1'b1;
                  next_r.nbits     = '0;
                  next_r.shreg     = '0;
                  // A full buffer closes the burst; later bits wait for the next one
                  if (bit_in.last || r.wr_cnt == FULL_CNT) begin
                     next_r.bit_ready = 1'b0;
                     next_r.st        = ST_WAIT;
                  end
               end else begin
                  next_r.shreg = sh;
                  next_r.nbits = n;
               end
            end
         end
         ST_WAIT: begin
            // A slot already past is only met again when the grid index wraps
            if (boundary && r.grid_idx == r.cfg.slot) begin
               rd_en         = 1'b1;
               next_r.rd_cnt = r.rd_cnt + 1'b1;
               next_r.acc    = '0;
               next_r.tx_on  = 1'b1;
               next_r.st     = ST_SEND;
            end
         end
         ST_SEND: begin
            // Rate held from the latched parameters for the whole burst
            acc_sum = {1'b0, r.acc} + {1'b0, sym_step(r.cfg.rate)};
            if (acc_sum >= GRID_MOD) begin
               acc_sum = acc_sum - GRID_MOD;
               // Last symbol keeps its full period, so guard time counts from here
               if (r.rd_cnt == r.wr_cnt) begin
                  next_r.burst_done = 1'b1;
                  next_r.cfg_ready  = 1'b1;
                  next_r.tx_on      = r.cfg.near_cont;
                  next_r.st         = ST_IDLE;
               end else begin
                  rd_en         = 1'b1;
                  next_r.rd_cnt = r.rd_cnt + 1'b1;
               end
            end
            next_r.acc = acc_sum[7:0];
         end
         default: begin
            next_r.st        = ST_IDLE;
            next_r.cfg_ready = 1'b1;
            next_r.bit_ready = 1'b0;
         end
      endcase

      // Buffer read data is one cycle old; map it into the output register
      next_r.rd_pend = rd_en;
      if (r.rd_pend) begin
         next_r.sym       = map_sym(rd_data, r.cfg);
         next_r.sym_valid = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r           <= '0;
         r.st        <= ST_IDLE;
         r.cfg_ready <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign cfg_ready  = r.cfg_ready;
   assign bit_ready  = r.bit_ready;
   assign sym_valid  = r.sym_valid;
   assign sym        = r.sym;
   assign tx_on      = r.tx_on;
   assign burst_done = r.burst_done;
   assign grid_index = r.grid_idx;

endmodule : ubsm_mapper

`default_nettype wire

// >>> common/ubsm_pkg.sv
// Shared constants and types of the upstream burst symbol mapper
`default_nettype none

package ubsm_pkg;

   // Clock and burst-grid timing
   localparam int CLK_KHZ           = 20000;
   localparam int GRID_NS           = 6250;
   localparam int GRID_CYC          = (GRID_NS * CLK_KHZ) / 1000000;
   localparam int FAST_SYM_PER_GRID = 16;
   localparam int SLOT_W            = 16;

   // Burst buffer, big enough for a longest preamble plus payload
   localparam int BUF_DEPTH = 1024;
   localparam int ADDR_W    = 10;
   localparam int CODE_W    = 4;

   // Quadrant held by the differential encoder at every burst start
   localparam logic [1:0] QUAD_REF = 2'b11;

   // Bits per symbol
   localparam logic [2:0] QPSK_BITS = 3'h2;
   localparam logic [2:0] QAM_BITS  = 3'h4;

   typedef enum logic [2:0] {
      RATE_160  = 3'h0,
      RATE_320  = 3'h1,
      RATE_640  = 3'h2,
      RATE_1280 = 3'h3,
      RATE_2560 = 3'h4
   } ubsm_rate_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_LOAD = 4'h2,
      ST_WAIT = 4'h4,
      ST_SEND = 4'h8
   } ubsm_state_t;

   // Per-burst parameters
   typedef struct packed {
      logic              qam16;
      logic              diff_en;
      ubsm_rate_t        rate;
      logic              near_cont;
      logic [SLOT_W-1:0] slot;
   } ubsm_cfg_t;

   // One serial input bit
   typedef struct packed {
      logic data;
      logic last;
   } ubsm_bit_t;

   // One mapped symbol: code is {inphase_high, quadrature_high, inphase_low, quadrature_low}
   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic signed [2:0] i_lvl;
      logic signed [2:0] q_lvl;
   } ubsm_sym_t;

   typedef struct packed {
      ubsm_state_t       st;
      ubsm_cfg_t         cfg;
      logic [3:0]        shreg;
      logic [2:0]        nbits;
      logic [1:0]        quad_prev;
      logic [ADDR_W:0]   wr_cnt;
      logic [ADDR_W:0]   rd_cnt;
      logic [6:0]        grid_cyc;
      logic [SLOT_W-1:0] grid_idx;
      logic [7:0]        acc;
      logic              rd_pend;
      logic              cfg_ready;
      logic              bit_ready;
      logic              sym_valid;
      ubsm_sym_t         sym;
      logic              tx_on;
      logic              burst_done;
   } ubsm_regs_t;

endpackage : ubsm_pkg

`default_nettype wire

// >>> hw/ubsm_sym_mem.sv
// Burst symbol buffer with registered read data
`default_nettype none

module ubsm_sym_mem #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 1024,
   parameter int AW    = 10
) (
   // Clock
   input  wire logic             sys_clk,
   // Write port
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   // Read port
   input  wire logic             rd_en,
   input  wire logic [AW-1:0]    rd_addr,
   output var  logic [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule : ubsm_sym_mem

`default_nettype wire

// >>> verif/ubsm_monitor.sv
// Port checker of the burst symbol mapper
`default_nettype none

module ubsm_monitor
   import ubsm_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Burst parameters and bit ready
   input  wire logic              cfg_valid,
   input  wire ubsm_cfg_t         cfg,
   input  wire logic              cfg_ready,
   input  wire logic              bit_ready,
   // Symbols and status
   input  wire logic              sym_valid,
   input  wire ubsm_sym_t         sym,
   input  wire logic              tx_on,
   input  wire logic              burst_done,
   input  wire logic [SLOT_W-1:0] grid_index
);
   timeunit 1ns;
   timeprecision 1ns;
   logic              qam_r;
   logic              first_r;
   logic [SLOT_W-1:0] slot_r;

   // Settings latched at take, the inputs move on afterwards
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         qam_r   <= 1'b0;
         first_r <= 1'b0;
         slot_r  <= '0;
      end else if (cfg_valid && cfg_ready) begin
         qam_r   <= cfg.qam16;
         first_r <= 1'b1;
         slot_r  <= cfg.slot;
      end else if (sym_valid) begin
         first_r <= 1'b0;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_take_answer: assert property (cfg_valid && cfg_ready |=>
      !cfg_ready && bit_ready) else $error("burst parameters not taken");
   chk_whole_burst: assert property (bit_ready |-> !sym_valid)
      else $error("symbol released while loading");
   chk_sym_txon: assert property (sym_valid |-> tx_on)
      else $error("symbol without envelope");
   chk_first_slot: assert property (sym_valid && first_r |-> grid_index == slot_r)
      else $error("burst started off its slot");
   chk_qpsk_bits: assert property (sym_valid && !qam_r |-> sym.code[1:0] == 2'h0
      && (sym.i_lvl == 3'sd1 || sym.i_lvl == -3'sd1)) else $error("bad qpsk symbol");
   chk_qam_sign: assert property (sym_valid && qam_r |-> sym.i_lvl[2] != sym.code[3]
      && sym.q_lvl[2] != sym.code[2] && sym.i_lvl != 3'sd0) else $error("bad 16qam level");
   chk_sym_gap: assert property (sym_valid |=> !sym_valid [*6])
      else $error("symbols too close");
   chk_done_pulse: assert property (burst_done |-> cfg_ready ##1 !burst_done)
      else $error("burst end not a pulse");
   chk_grid_step: assert property ($changed(grid_index) |->
      grid_index == $past(grid_index) + 16'h1) else $error("grid index skipped");
endmodule : ubsm_monitor

`default_nettype wire

// >>> verif/ubsm_sink_model.sv
// Headend-side symbol sink: records every released symbol
`default_nettype none

module ubsm_sink_model
   import ubsm_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Symbols from the mapper
   input  wire logic              sym_valid,
   input  wire ubsm_sym_t         sym,
   input  wire logic              tx_on,
   input  wire logic [SLOT_W-1:0] grid_index
);
   timeunit 1ns;
   timeprecision 1ns;
   ubsm_sym_t         syms[$];
   int                cyc[$];
   logic [SLOT_W-1:0] grids[$];
   int                now;

   // Either format is taken, acquisition gated by the envelope
   always @(posedge sys_clk) begin
      now++;
      if (!rst && sym_valid && tx_on) begin
         syms.push_back(sym);
         cyc.push_back(now);
         grids.push_back(grid_index);
      end
   end
endmodule : ubsm_sink_model

`default_nettype wire

// >>> verif/ubsm_mapper_tb.sv
// Self-checking bench of the burst symbol mapper
`default_nettype none

module ubsm_mapper_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ubsm_pkg::*;
   logic              sys_clk, rst, cfg_valid, cfg_ready, bit_valid, bit_ready;
   logic              sym_valid, tx_on, burst_done;
   ubsm_cfg_t         cfg;
   ubsm_bit_t         bit_in;
   ubsm_sym_t         sym;
   logic [SLOT_W-1:0] grid_index;
   logic [SLOT_W-1:0] slot_exp;
   int                error_cnt, checks, gap, r, n, span;

   ubsm_mapper ubsm_mapper_inst (.sys_clk(sys_clk), .rst(rst), .cfg_valid(cfg_valid), .cfg(cfg),
      .cfg_ready(cfg_ready), .bit_valid(bit_valid), .bit_in(bit_in), .bit_ready(bit_ready),
      .sym_valid(sym_valid), .sym(sym), .tx_on(tx_on), .burst_done(burst_done),
      .grid_index(grid_index));
   ubsm_sink_model ubsm_sink_model_inst (.sys_clk(sys_clk), .rst(rst), .sym_valid(sym_valid),
      .sym(sym), .tx_on(tx_on), .grid_index(grid_index));

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic results();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results

   // Bounded wait for idle, or for n symbols when n > 0
   task automatic await(input int want);
      int k;
      for (k = 0; k < 4000; k++) begin
         if (want == 0 ? cfg_ready === 1'b1 : ubsm_sink_model_inst.syms.size() >= want) break;
         @(posedge sys_clk) #5;
      end
      if (k == 4000) begin
         error_cnt++;
         $display("Error timeout");
         results();
      end
   endtask : await

   // Slot two grids ahead leaves far more than the guard band
   task automatic burst(input logic qam, input logic diff, input logic [2:0] rate,
                        input logic near, input logic [15:0] bits, input int nb);
      int k;
      await(0);
      ubsm_sink_model_inst.syms.delete();
      ubsm_sink_model_inst.cyc.delete();
      ubsm_sink_model_inst.grids.delete();
      slot_exp = grid_index + 16'h2;
      cfg = '{qam, diff, ubsm_rate_t'(rate), near, slot_exp};
      cfg_valid = 1'b1;
      @(posedge sys_clk) #5;
      cfg_valid = 1'b0;
      for (k = nb - 1; k >= 0; k--) begin
         bit_in = '{bits[k], k == 0};
         bit_valid = 1'b1;
         @(posedge sys_clk) #5;
      end
      bit_valid = 1'b0;
      await(nb / (qam ? 4 : 2));
      check("start grid", slot_exp, ubsm_sink_model_inst.grids[0]);
   endtask : burst

   function automatic logic [15:0] code_of(input int i);
      return {12'h0, ubsm_sink_model_inst.syms[i].code};
   endfunction : code_of

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   initial begin
      rst = 1'b1;
      cfg_valid = 1'b0;
      cfg = '0;
      bit_valid = 1'b0;
      bit_in = '0;
      repeat (6) @(posedge sys_clk);
      #5 rst = 1'b0;
      burst(1'b0, 1'b0, 3'h4, 1'b0, 16'h0009, 4);
      check("qpsk sym0", 16'h8, code_of(0));
      check("qpsk sym1", 16'h4, code_of(1));
      burst(1'b1, 1'b0, 3'h4, 1'b0, 16'h0086, 8);
      check("qam sym0", 16'h8, code_of(0));
      check("qam i0", 16'h3, {13'h0, ubsm_sink_model_inst.syms[0].i_lvl});
      check("qam q0", 16'h5, {13'h0, ubsm_sink_model_inst.syms[0].q_lvl});
      check("qam i1", 16'h7, {13'h0, ubsm_sink_model_inst.syms[1].i_lvl});
      burst(1'b1, 1'b1, 3'h4, 1'b0, 16'h04f0, 12);
      check("diff sym0", 16'h4, code_of(0));
      check("diff sym1", 16'hb, code_of(1));
      check("diff sym2", 16'h8, code_of(2));
      for (n = 0; n < 2; n++) begin
         burst(1'b0, 1'b1, 3'h4, 1'b0, 16'h0009, 4);
         check("qpsk diff sym0", 16'h8, code_of(0));
         check("qpsk diff sym1", 16'hc, code_of(1));
      end
      // Unused rate codes fall back to the slowest rate
      burst(1'b0, 1'b0, 3'h7, 1'b0, 16'h001b, 4);
      gap = ubsm_sink_model_inst.cyc[1] - ubsm_sink_model_inst.cyc[0];
      check("fallback spacing", 16'(GRID_CYC), 16'(gap));
      for (r = 0; r < 5; r++) begin
         burst(1'b0, 1'b0, r[2:0], r == 4, 16'h001b, 4);
         gap = ubsm_sink_model_inst.cyc[1] - ubsm_sink_model_inst.cyc[0];
         span = GRID_CYC >> r;
         check("symbol spacing", 16'h1, {15'h0, gap >= span && gap <= span + 1});
      end
      await(0);
      repeat (3) @(posedge sys_clk);
      #5;
      check("envelope held", 16'h1, {15'h0, tx_on});
      burst(1'b0, 1'b0, 3'h0, 1'b0, 16'h0002, 2);
      await(0);
      repeat (3) @(posedge sys_clk);
      #5;
      check("envelope off", 16'h0, {15'h0, tx_on});
      results();
   end
endmodule : ubsm_mapper_tb

bind ubsm_mapper ubsm_monitor ubsm_monitor_inst (.sys_clk(sys_clk), .rst(rst),
   .cfg_valid(cfg_valid), .cfg(cfg), .cfg_ready(cfg_ready), .bit_ready(bit_ready),
   .sym_valid(sym_valid), .sym(sym), .tx_on(tx_on), .burst_done(burst_done),
   .grid_index(grid_index));

`default_nettype wire
